/* design/rasd_cfg.svh */
`ifndef RASD_CFG_SVH
`define RASD_CFG_SVH

// register sizes in bytes
`define RASD_RF_BYTES 10
`define RASD_TXP_BYTES 32
`define RASD_TXA_BYTES 4
`define RASD_RXP_BYTES 32
`define RASD_ADCC_BYTES 3
`define RASD_ADCD_BYTES 2

// opcodes, high nibble, top seven bits or full byte
`define RASD_OP_WRC 4'h0
`define RASD_OP_RRC 4'h1
`define RASD_OP_WTP 8'h20
`define RASD_OP_RTP 8'h21
`define RASD_OP_WTA 8'h22
`define RASD_OP_RTA 8'h23
`define RASD_OP_RRP 8'h24
`define RASD_OP_RAD 7'h20
`define RASD_OP_WAC 8'h44
`define RASD_OP_RAC 8'h46
`define RASD_OP_CC 4'h8
`define RASD_OP_SAC 4'hC

// status byte bit positions
`define RASD_ST_AM 7
`define RASD_ST_DR 5
`define RASD_ST_EOC 3
`define RASD_ST_RDY 2

// radio config field placement
`define RASD_RF_CHLO_BYTE 0
`define RASD_RF_CTRL_BYTE 1
`define RASD_RF_CHHI_BIT 0
`define RASD_RF_BAND_BIT 1
`define RASD_RF_PWR_LSB 2

// reset values and index limit
`define RASD_RF_RST 80'hC0E7E7E7E7202044006C
`define RASD_TXA_RST 32'hE7E7E7E7
`define RASD_ADCC_RST 24'h000000
`define RASD_IDX_MAX 6'h3F

`endif

/* design/rasd_pkg.sv */
package rasd_pkg;
`include "rasd_cfg.svh"

typedef enum logic [3:0] {
   ST_IDLE = 4'h0,
   ST_OPCODE = 4'h1,
   ST_WR_RF = 4'h2,
   ST_RD_RF = 4'h3,
   ST_WR_TXP = 4'h4,
   ST_RD_TXP = 4'h5,
   ST_WR_TXA = 4'h6,
   ST_RD_TXA = 4'h7,
   ST_RD_RXP = 4'h8,
   ST_RD_ADC = 4'h9,
   ST_WR_ADCC = 4'hA,
   ST_RD_ADCC = 4'hB,
   ST_CHAN2 = 4'hC,
   ST_IGNORE = 4'hD
} rasd_state_type;

typedef struct packed {
   logic [1:0][7:0] mem;
   logic wp;
   logic rp;
   logic [1:0] cnt;
} rasd_fifo_type;

typedef struct packed {
   logic [1:0] csn_s;
   logic [1:0] sck_s;
   logic [1:0] mosi_s;
   logic csn_d;
   logic sck_d;
   logic [2:0] bits;
   logic [7:0] rx_sh;
   logic [7:0] tx_sh;
   logic load_next;
   logic push;
   logic [7:0] push_data;
   logic fstart;
   logic fend;
} rasd_port_type;

typedef struct packed {
   rasd_state_type state;
   logic [5:0] idx;
   logic [`RASD_RF_BYTES-1:0][7:0] rf;
   logic [`RASD_TXP_BYTES-1:0][7:0] txp;
   logic [`RASD_TXA_BYTES-1:0][7:0] txa;
   logic [`RASD_ADCC_BYTES-1:0][7:0] adcc;
   logic [7:0] cc_hold;
   logic [3:0] src;
   logic conv_pend;
   logic conv_start;
} rasd_dec_type;

endpackage

/* design/rasd_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rasd_stream_if;
   logic [7:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

/* design/rasd_byte_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module rasd_byte_fifo (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic flush_in,
   rasd_stream_if.snk wr,
   rasd_stream_if.src rd
);
   import rasd_pkg::*;
   rasd_fifo_type fifo_reg;
   rasd_fifo_type fifo_next;
   logic push;
   logic pop;

   assign wr.ready = (fifo_reg.cnt != 2'h2);
   assign rd.valid = (fifo_reg.cnt != 2'h0);
   assign rd.data = fifo_reg.mem[fifo_reg.rp];
   assign push = wr.valid & wr.ready;
   assign pop = rd.valid & rd.ready;

   always_comb begin
      fifo_next = fifo_reg;
      if (push) begin
         fifo_next.mem[fifo_reg.wp] = wr.data;
         fifo_next.wp = ~fifo_reg.wp;
      end
      if (pop) begin
         fifo_next.rp = ~fifo_reg.rp;
      end
      fifo_next.cnt = fifo_reg.cnt + {1'b0, push} - {1'b0, pop};
      if (flush_in) begin
         fifo_next.wp = 1'b0;
         fifo_next.rp = 1'b0;
         fifo_next.cnt = 2'h0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fifo_reg <= '0;
      end else begin
         fifo_reg <= fifo_next;
      end
   end
endmodule
`default_nettype wire

/* design/rasd_spi_port.sv */
`timescale 1ns/1ps
`default_nettype none
module rasd_spi_port (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic csn_in,
   input wire logic [7:0] status_in,
   input wire logic [7:0] rd_byte_in,
   output logic miso_out,
   output logic csn_level_out,
   output logic frame_start_out,
   output logic frame_end_out,
   rasd_stream_if.src rx
);
   import rasd_pkg::*;
   rasd_port_type port_reg;
   rasd_port_type port_next;
   logic csn;
   logic sck;
   logic mosi;

   assign csn = port_reg.csn_s[1];
   assign sck = port_reg.sck_s[1];
   assign mosi = port_reg.mosi_s[1];
   assign miso_out = port_reg.tx_sh[7];
   assign csn_level_out = port_reg.csn_d;
   assign frame_start_out = port_reg.fstart;
   assign frame_end_out = port_reg.fend;
   assign rx.valid = port_reg.push;
   assign rx.data = port_reg.push_data;

   always_comb begin
      port_next = port_reg;
      port_next.csn_s = {port_reg.csn_s[0], csn_in};
      port_next.sck_s = {port_reg.sck_s[0], sck_in};
      port_next.mosi_s = {port_reg.mosi_s[0], mosi_in};
      port_next.csn_d = csn;
      port_next.sck_d = sck;
      port_next.fstart = port_reg.csn_d & ~csn;
      port_next.fend = ~port_reg.csn_d & csn;
      // byte held until the buffer takes it
      if (rx.ready) begin
         port_next.push = 1'b0;
      end
      if (port_reg.csn_d && !csn) begin
         port_next.tx_sh = status_in; // [R15]
         port_next.bits = 3'h0;
         port_next.load_next = 1'b0;
      end else if (!csn) begin
         if (sck && !port_reg.sck_d) begin
            // sample on rising edge, msb first
            port_next.rx_sh = {port_reg.rx_sh[6:0], mosi}; // [R18] [R17]
            port_next.bits = port_reg.bits + 3'h1;
            if (port_reg.bits == 3'h7) begin
               port_next.push = 1'b1;
               port_next.push_data = {port_reg.rx_sh[6:0], mosi};
               port_next.load_next = 1'b1;
            end
         end else if (!sck && port_reg.sck_d) begin
            // output moves on the falling edge
            if (port_reg.load_next) begin
               port_next.tx_sh = rd_byte_in; // [R25]
               port_next.load_next = 1'b0;
            end else begin
               port_next.tx_sh = {port_reg.tx_sh[6:0], 1'b0}; // [R25]
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         port_reg <= '0;
         port_reg.csn_s <= 2'h3;
         port_reg.csn_d <= 1'b1;
      end else begin
         port_reg <= port_next;
      end
   end
endmodule
`default_nettype wire

/* design/rasd_spi_decoder.sv */
// Functional notes
// [R1] first byte after chip select falls is taken as the opcode
// [R2] master gives a fresh chip-select fall before each instruction
// [R3] opcode 0000 AAAA writes radio config from byte AAAA to its end
// [R4] opcode 0001 AAAA reads radio config from byte AAAA onward
// [R5] opcode 20h writes the transmit payload, 1 to 32 bytes from byte 0
// [R6] opcode 21h reads back the transmit payload from byte 0
// [R7] opcode 22h writes the transmit address, 1 to 4 bytes from byte 0
// [R8] opcode 23h reads back the transmit address from byte 0
// [R9] opcode 24h returns the receive payload from byte 0
// [R10] opcode 0100 000A reads converter result starting at byte A
// [R11] opcode 44h writes converter config, up to 3 bytes, byte 2 reserved
// [R12] opcode 46h reads converter config, up to 3 bytes from byte 0
// [R13] two-byte 1000 pphc command sets power, band and 9-bit channel at once
// [R14] opcode 1100 ssss starts a conversion with ssss as source select
// [R15] status byte shifts out during the first byte of every frame
// [R16] transfers run one byte or many, advancing from the start byte
// [R17] lowest byte first, most significant bit first
// [R18] serial mode 0: clock idles low, sampled on rising edge
// [R19] master touches config only while the radio is in power save
// [R20] master drives clock, data in, data out, select on its port bits 0-3
// [R21] conversion starts once converter select returns high; restart aborts
// [R22] status holds data ready, address match, end of conversion, ready
// [R23] channel is nine bits, band one bit, power two bits
// [R24] unknown opcodes ignored until the next chip-select frame
// [R25] serial output changes on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
`include "rasd_cfg.svh"
module rasd_spi_decoder (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic csn_in,
   output logic miso_out,
   input wire logic [`RASD_RXP_BYTES*8-1:0] rx_payload_in,
   input wire logic [`RASD_ADCD_BYTES*8-1:0] adc_data_in,
   input wire logic rx_data_ready_flag_in,
   input wire logic addr_match_flag_in,
   input wire logic conv_eoc_in,
   input wire logic conv_ready_in,
   output logic [`RASD_RF_BYTES*8-1:0] rf_cfg_out,
   output logic [8:0] carrier_channel_number_out,
   output logic band_select_bit_out,
   output logic [1:0] output_power_level_out,
   output logic [`RASD_TXP_BYTES*8-1:0] tx_payload_out,
   output logic [`RASD_TXA_BYTES*8-1:0] tx_addr_out,
   output logic [`RASD_ADCC_BYTES*8-1:0] adc_cfg_out,
   output logic [3:0] conv_source_select_out,
   output logic conv_start_out,
   output logic converter_chip_select_out
);
   import rasd_pkg::*;

   ////////////////////////////////////////////////////////////
   // reset release and state

   logic [1:0] rst_sync_reg;
   logic rst_n;
   rasd_dec_type dec_reg;
   rasd_dec_type dec_next;
   logic frame_start;
   logic frame_end;
   logic csn_level;
   logic [7:0] status_byte;
   logic [7:0] rd_byte;
   logic [7:0] in_byte;
   logic take;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   ////////////////////////////////////////////////////////////
   // serial port and byte buffer

   rasd_stream_if port_bus ();
   rasd_stream_if dec_bus ();

   always_comb begin
      status_byte = 8'h00;
      status_byte[`RASD_ST_AM] = addr_match_flag_in; // [R22]
      status_byte[`RASD_ST_DR] = rx_data_ready_flag_in; // [R22]
      status_byte[`RASD_ST_EOC] = conv_eoc_in; // [R22]
      status_byte[`RASD_ST_RDY] = conv_ready_in; // [R22]
   end

   rasd_spi_port u_port (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .sck_in(sck_in),
      .mosi_in(mosi_in),
      .csn_in(csn_in),
      .status_in(status_byte),
      .rd_byte_in(rd_byte),
      .miso_out(miso_out),
      .csn_level_out(csn_level),
      .frame_start_out(frame_start),
      .frame_end_out(frame_end),
      .rx(port_bus.src)
   );

   // leftovers of an old frame are dropped at a new one
   rasd_byte_fifo u_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .flush_in(frame_start),
      .wr(port_bus.snk),
      .rd(dec_bus.src)
   );

   // decoder pauses while a frame edge is being handled
   assign dec_bus.ready = ~frame_start & ~frame_end;
   assign take = dec_bus.valid & dec_bus.ready;
   assign in_byte = dec_bus.data;

   ////////////////////////////////////////////////////////////
   // helpers

   // one bounds check for every indexed store and fetch
   // out-of-range bytes are dropped, never aliased
   function automatic logic in_range(input logic [5:0] idx, input logic [5:0] lim);
      in_range = (idx < lim);
   endfunction

   function automatic logic [5:0] bump(input logic [5:0] idx);
      // saturate so a long burst never wraps onto byte 0
      if (idx == `RASD_IDX_MAX) begin
         bump = idx;
      end else begin
         bump = idx + 6'h01;
      end
   endfunction

   ////////////////////////////////////////////////////////////
   // read data for the next outgoing byte

   // chosen from state and index one byte ahead
   // so the port can load it on the falling edge
   always_comb begin
      rd_byte = 8'h00;
      case (dec_reg.state)
         ST_RD_RF: begin
            if (in_range(dec_reg.idx, 6'(`RASD_RF_BYTES))) begin
               rd_byte = dec_reg.rf[dec_reg.idx[3:0]]; // [R4]
            end
         end

         ST_RD_TXP: begin
            if (in_range(dec_reg.idx, 6'(`RASD_TXP_BYTES))) begin
               rd_byte = dec_reg.txp[dec_reg.idx[4:0]]; // [R6]
            end
         end

         ST_RD_TXA: begin
            if (in_range(dec_reg.idx, 6'(`RASD_TXA_BYTES))) begin
               rd_byte = dec_reg.txa[dec_reg.idx[1:0]]; // [R8]
            end
         end

         ST_RD_RXP: begin
            if (in_range(dec_reg.idx, 6'(`RASD_RXP_BYTES))) begin
               rd_byte = rx_payload_in[{dec_reg.idx[4:0], 3'h0} +: 8]; // [R9]
            end
         end

         ST_RD_ADC: begin
            if (in_range(dec_reg.idx, 6'(`RASD_ADCD_BYTES))) begin
               rd_byte = adc_data_in[{dec_reg.idx[0], 3'h0} +: 8]; // [R10]
            end
         end

         ST_RD_ADCC: begin
            if (in_range(dec_reg.idx, 6'(`RASD_ADCC_BYTES))) begin
               rd_byte = dec_reg.adcc[dec_reg.idx[1:0]]; // [R12]
            end
         end

         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////
   // command decoding

   // frame edges outrank bytes: a stale byte never
   // runs into the next instruction
   always_comb begin
      dec_next = dec_reg;
      dec_next.conv_start = 1'b0;
      if (frame_start) begin
         dec_next.state = ST_OPCODE; // [R1]
         dec_next.idx = 6'h00;
         dec_next.conv_pend = 1'b0;
      end else if (frame_end) begin
         // conversion released only once select is high again
         dec_next.conv_start = dec_reg.conv_pend; // [R21]
         dec_next.conv_pend = 1'b0;
         dec_next.state = ST_IDLE;
      end else if (take) begin
         case (dec_reg.state)
            ST_OPCODE: begin
               dec_next.idx = 6'h00;
               dec_next.state = ST_IGNORE; // [R24]
               if (in_byte[7:4] == `RASD_OP_WRC) begin
                  dec_next.state = ST_WR_RF; // [R3]
                  dec_next.idx = {2'h0, in_byte[3:0]};
               end else if (in_byte[7:4] == `RASD_OP_RRC) begin
                  dec_next.state = ST_RD_RF; // [R4]
                  dec_next.idx = {2'h0, in_byte[3:0]};
               end else if (in_byte == `RASD_OP_WTP) begin
                  dec_next.state = ST_WR_TXP; // [R5]
               end else if (in_byte == `RASD_OP_RTP) begin
                  dec_next.state = ST_RD_TXP; // [R6]
               end else if (in_byte == `RASD_OP_WTA) begin
                  dec_next.state = ST_WR_TXA; // [R7]
               end else if (in_byte == `RASD_OP_RTA) begin
                  dec_next.state = ST_RD_TXA; // [R8]
               end else if (in_byte == `RASD_OP_RRP) begin
                  dec_next.state = ST_RD_RXP; // [R9]
               end else if (in_byte[7:1] == `RASD_OP_RAD) begin
                  dec_next.state = ST_RD_ADC; // [R10]
                  dec_next.idx = {5'h00, in_byte[0]};
               end else if (in_byte == `RASD_OP_WAC) begin
                  dec_next.state = ST_WR_ADCC; // [R11]
               end else if (in_byte == `RASD_OP_RAC) begin
                  dec_next.state = ST_RD_ADCC; // [R12]
               end else if (in_byte[7:4] == `RASD_OP_CC) begin
                  dec_next.state = ST_CHAN2; // [R13]
                  dec_next.cc_hold = in_byte;
               end else if (in_byte[7:4] == `RASD_OP_SAC) begin
                  dec_next.src = in_byte[3:0]; // [R14]
                  // a second start simply re-arms; converter aborts the old one
                  dec_next.conv_pend = 1'b1; // [R21]
               end
            end

            ST_WR_RF: begin
               if (in_range(dec_reg.idx, 6'(`RASD_RF_BYTES))) begin
                  dec_next.rf[dec_reg.idx[3:0]] = in_byte; // [R3]
               end
               dec_next.idx = bump(dec_reg.idx); // [R16]
            end

            ST_WR_TXP: begin
               if (in_range(dec_reg.idx, 6'(`RASD_TXP_BYTES))) begin
                  dec_next.txp[dec_reg.idx[4:0]] = in_byte; // [R5]
               end
               dec_next.idx = bump(dec_reg.idx); // [R16]
            end

            ST_WR_TXA: begin
               if (in_range(dec_reg.idx, 6'(`RASD_TXA_BYTES))) begin
                  dec_next.txa[dec_reg.idx[1:0]] = in_byte; // [R7]
               end
               dec_next.idx = bump(dec_reg.idx); // [R16]
            end

            ST_WR_ADCC: begin
               // reserved byte 2 is stored and read back unchanged
               if (in_range(dec_reg.idx, 6'(`RASD_ADCC_BYTES))) begin
                  dec_next.adcc[dec_reg.idx[1:0]] = in_byte; // [R11]
               end
               dec_next.idx = bump(dec_reg.idx); // [R16]
            end

            ST_RD_RF, ST_RD_TXP, ST_RD_TXA, ST_RD_RXP, ST_RD_ADC, ST_RD_ADCC: begin
               // dummy byte in, next byte out
               dec_next.idx = bump(dec_reg.idx); // [R16] [R17]
            end

            // second byte of the channel command
            ST_CHAN2: begin
               dec_next.rf[`RASD_RF_CHLO_BYTE] = in_byte; // [R13]
               dec_next.rf[`RASD_RF_CTRL_BYTE][`RASD_RF_CHHI_BIT] = dec_reg.cc_hold[0]; // [R13]
               dec_next.rf[`RASD_RF_CTRL_BYTE][`RASD_RF_BAND_BIT] = dec_reg.cc_hold[1]; // [R13]
               dec_next.rf[`RASD_RF_CTRL_BYTE][`RASD_RF_PWR_LSB +: 2] = dec_reg.cc_hold[3:2]; // [R13]
               dec_next.state = ST_IGNORE;
            end

            ST_IGNORE, ST_IDLE: begin
               dec_next.state = dec_reg.state; // [R24]
            end

            default: begin
               dec_next.state = ST_IGNORE;
            end
         endcase
      end
   end

   // rf and tx address come up at their defaults
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         dec_reg <= '0;
         dec_reg.state <= ST_IDLE;
         dec_reg.rf <= `RASD_RF_RST;
         dec_reg.txa <= `RASD_TXA_RST;
         dec_reg.adcc <= `RASD_ADCC_RST;
      end else begin
         dec_reg <= dec_next;
      end
   end

   ////////////////////////////////////////////////////////////
   // outputs

   // all outputs are straight register copies
   assign rf_cfg_out = dec_reg.rf;
   assign tx_payload_out = dec_reg.txp;
   assign tx_addr_out = dec_reg.txa;
   assign adc_cfg_out = dec_reg.adcc;
   assign conv_source_select_out = dec_reg.src;
   assign conv_start_out = dec_reg.conv_start;
   assign converter_chip_select_out = csn_level;
   assign carrier_channel_number_out = {dec_reg.rf[`RASD_RF_CTRL_BYTE][`RASD_RF_CHHI_BIT],
                                        dec_reg.rf[`RASD_RF_CHLO_BYTE]}; // [R23]
   assign band_select_bit_out = dec_reg.rf[`RASD_RF_CTRL_BYTE][`RASD_RF_BAND_BIT]; // [R23]
   assign output_power_level_out = dec_reg.rf[`RASD_RF_CTRL_BYTE][`RASD_RF_PWR_LSB +: 2]; // [R23]

endmodule
`default_nettype wire

/* bench/rasd_spi_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rasd_cfg.svh"
module rasd_spi_props (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic sck_in,
   input wire logic csn_in,
   input wire logic miso_out,
   input wire logic [`RASD_RF_BYTES*8-1:0] rf_cfg_out,
   input wire logic [8:0] carrier_channel_number_out,
   input wire logic band_select_bit_out,
   input wire logic [1:0] output_power_level_out,
   input wire logic [`RASD_TXP_BYTES*8-1:0] tx_payload_out,
   input wire logic [`RASD_TXA_BYTES*8-1:0] tx_addr_out,
   input wire logic [`RASD_ADCC_BYTES*8-1:0] adc_cfg_out,
   input wire logic conv_start_out,
   input wire logic converter_chip_select_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   logic sck_q, csn_q;
   logic [5:0] fall_hist;
   logic [4:0] hi_cnt;
   ////////////////////////////////////////////////////////////
   // miso may only move a few cycles after a clock or select fall
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sck_q <= 1'b0;
         csn_q <= 1'b1;
         fall_hist <= '0;
         hi_cnt <= '0;
      end else begin
         sck_q <= sck_in;
         csn_q <= csn_in;
         fall_hist <= {fall_hist[4:0], (sck_q & ~sck_in) | (csn_q & ~csn_in)};
         if (!csn_in) hi_cnt <= '0;
         else if (hi_cnt != 5'd31) hi_cnt <= hi_cnt + 5'd1;
      end
   end
   ////////////////////////////////////////////////////////////
   a_miso_after_fall: assert property ($changed(miso_out) |-> |fall_hist)
      else $error("serial output moved without a clock fall");
   a_cfg_quiet_idle: assert property ((hi_cnt >= 5'd16) |-> $stable(rf_cfg_out) && $stable(tx_payload_out)
      && $stable(tx_addr_out) && $stable(adc_cfg_out))
      else $error("register changed while deselected");
   a_start_one_cycle: assert property (conv_start_out |=> !conv_start_out)
      else $error("start pulse longer than one cycle");
   a_start_after_deselect: assert property (conv_start_out |-> $past(csn_in, 2) ##[0:2] converter_chip_select_out)
      else $error("start pulse before select returned high");
   a_sel_rise_follows: assert property ($rose(csn_in) |-> ##[1:4] converter_chip_select_out)
      else $error("converter select did not follow pin rise");
   a_sel_fall_follows: assert property ($fell(csn_in) |-> ##[1:4] !converter_chip_select_out)
      else $error("converter select did not follow pin fall");
   a_chan_from_cfg: assert property (carrier_channel_number_out == {rf_cfg_out[8], rf_cfg_out[7:0]})
      else $error("channel output differs from config");
   a_band_power_cfg: assert property ({output_power_level_out, band_select_bit_out}
      == {rf_cfg_out[11:10], rf_cfg_out[9]})
      else $error("band or power differs from config");
   c_start: cover property (conv_start_out);
   c_payload: cover property ($changed(tx_payload_out));
   c_channel: cover property ($changed(carrier_channel_number_out));
endmodule
`default_nettype wire

/* bench/rasd_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rasd_master_model (
   output logic sck_out,
   output logic mosi_out,
   output logic csn_out,
   input wire logic miso_in
);
   localparam time HALF = 160;
   initial begin
      sck_out = 1'b0;
      mosi_out = 1'b1;
      csn_out = 1'b1;
   end
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi_out = tx[i];
         #HALF sck_out = 1'b1;
         rx[i] = miso_in;
         #HALF sck_out = 1'b0;
      end
   endtask
   task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
      logic [7:0] b;
      rx = {};
      csn_out = 1'b0;
      #(2*HALF);
      foreach (tx[k]) begin
         xfer(tx[k], b);
         rx.push_back(b);
      end
      #HALF csn_out = 1'b1;
      // released data line shows no stale value
      mosi_out = ~mosi_out;
      #(4*HALF);
   endtask
endmodule
`default_nettype wire

/* bench/radio_adc_spi_command_decoder_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rasd_cfg.svh"
module radio_adc_spi_command_decoder_bench;
   import rasd_pkg::*;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic sck, mosi, csn, miso, dr, am, eoc, rdy, band, start, csel;
   logic [255:0] rxp, txp, exp_p;
   logic [15:0] adcd;
   logic [79:0] rfc, rf_exp;
   logic [8:0] chan;
   logic [1:0] pwr;
   logic [31:0] txa;
   logic [23:0] adcc;
   logic [3:0] src;
   logic [7:0] st_exp;
   logic [7:0] rx[$];
   logic [7:0] q[$];
   logic [7:0] bad_ops[3] = '{8'h25, 8'h45, 8'hFF};
   int bad_count = 0;
   int checks_done = 0;
   int pulses = 0;
   always #20 clk_in = ~clk_in;
   always @(posedge clk_in) if (start === 1'b1) pulses++;
   rasd_spi_decoder dut_u (
      .clk_in(clk_in), .resetn_in(resetn_in), .sck_in(sck), .mosi_in(mosi), .csn_in(csn),
      .miso_out(miso), .rx_payload_in(rxp), .adc_data_in(adcd), .rx_data_ready_flag_in(dr),
      .addr_match_flag_in(am), .conv_eoc_in(eoc), .conv_ready_in(rdy), .rf_cfg_out(rfc),
      .carrier_channel_number_out(chan), .band_select_bit_out(band), .output_power_level_out(pwr),
      .tx_payload_out(txp), .tx_addr_out(txa), .adc_cfg_out(adcc), .conv_source_select_out(src),
      .conv_start_out(start), .converter_chip_select_out(csel)
   );
   rasd_master_model mst_u (.sck_out(sck), .mosi_out(mosi), .csn_out(csn), .miso_in(miso));
   ////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [255:0] e, input logic [255:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic flags(input logic [3:0] v);
      @(posedge clk_in);
      #1;
      {am, dr, eoc, rdy} = v;
      st_exp = 8'h00;
      st_exp[`RASD_ST_AM] = v[3];
      st_exp[`RASD_ST_DR] = v[2];
      st_exp[`RASD_ST_EOC] = v[1];
      st_exp[`RASD_ST_RDY] = v[0];
   endtask
   task automatic run(input logic [7:0] tx[$]);
      mst_u.frame(tx, rx);
      cmp("status", st_exp, rx[0]);
   endtask
   task automatic rd(input logic [7:0] op, input int n);
      q = {op};
      repeat (n) q.push_back(8'h00);
      run(q);
   endtask
   function automatic logic [255:0] got(input int n);
      logic [255:0] r = '0;
      for (int k = 0; k < n; k++) r[8*k +: 8] = rx[k+1];
      return r;
   endfunction
   ////////////////////////////////////////////////////////////
   initial begin
      rxp = '0;
      adcd = '0;
      {am, dr, eoc, rdy} = 4'h0;
      st_exp = 8'h00;
      rf_exp = `RASD_RF_RST;
      repeat (2) @(posedge clk_in);
      #1 resetn_in = 1'b1;
      repeat (4) @(posedge clk_in);
      cmp("rf_cfg", rf_exp, rfc);
      cmp("channel", 9'd108, chan);
      cmp("tx_addr", `RASD_TXA_RST, txa);
      cmp("conv_select", 1'b1, csel);
      $display("test reset done");
      flags(4'b1010);
      run('{8'h22, 8'h11, 8'h22, 8'h33, 8'h44});
      cmp("tx_addr", 32'h44332211, txa);
      rd(8'h23, 5);
      cmp("tx_addr_rd", 40'h0044332211, got(5));
      run('{8'h22, 8'h99});
      cmp("tx_addr", 32'h44332299, txa);
      $display("test tx address done");
      flags(4'b0101);
      run('{8'h08, 8'hA5, 8'h5A});
      rf_exp[79:64] = 16'h5AA5;
      cmp("rf_cfg", rf_exp, rfc);
      rd(8'h17, 3);
      cmp("rf_cfg_rd", rf_exp[79:56], got(3));
      run('{8'h8B, 8'h5A});
      rf_exp[11:0] = 12'hB5A;
      cmp("rf_cfg", rf_exp, rfc);
      cmp("fields", {2'b10, 1'b1, 9'h15A}, {pwr, band, chan});
      foreach (bad_ops[k]) run('{bad_ops[k], 8'h00, 8'h11});
      cmp("rf_cfg", rf_exp, rfc);
      cmp("tx_addr", 32'h44332299, txa);
      $display("test config done");
      q = {8'h20};
      for (int k = 0; k < 32; k++) begin
         q.push_back(8'(k * 7 + 3));
         exp_p[8*k +: 8] = 8'(k * 7 + 3);
      end
      run(q);
      cmp("tx_payload", exp_p, txp);
      rd(8'h21, 32);
      cmp("tx_payload_rd", exp_p, got(32));
      @(posedge clk_in);
      #1;
      for (int k = 0; k < 32; k++) rxp[8*k +: 8] = 8'hF0 ^ 8'(k);
      adcd = 16'hBEEF;
      rd(8'h24, 3);
      cmp("rx_payload_rd", 24'hF2F1F0, got(3));
      $display("test payload done");
      rd(8'h40, 2);
      cmp("adc_rd0", 16'hBEEF, got(2));
      rd(8'h41, 2);
      cmp("adc_rd1", 16'h00BE, got(2));
      run('{8'h44, 8'h12, 8'h34, 8'h56});
      cmp("adc_cfg", 24'h563412, adcc);
      rd(8'h46, 3);
      cmp("adc_cfg_rd", 24'h563412, got(3));
      run('{8'hC5});
      cmp("conv_src", 4'h5, src);
      cmp("conv_pulses", 1, pulses);
      run('{8'hC9});
      cmp("conv_src", 4'h9, src);
      cmp("conv_pulses", 2, pulses);
      $display("test converter done");
      conclude();
   end
   initial begin
      #2000000;
      bad_count++;
      $display("MISMATCH watchdog expected done seen timeout");
      conclude();
   end
endmodule
bind rasd_spi_decoder rasd_spi_props props_u (
   .clk_in(clk_in), .resetn_in(resetn_in), .sck_in(sck_in), .csn_in(csn_in), .miso_out(miso_out),
   .rf_cfg_out(rf_cfg_out), .carrier_channel_number_out(carrier_channel_number_out),
   .band_select_bit_out(band_select_bit_out), .output_power_level_out(output_power_level_out),
   .tx_payload_out(tx_payload_out), .tx_addr_out(tx_addr_out), .adc_cfg_out(adc_cfg_out),
   .conv_start_out(conv_start_out), .converter_chip_select_out(converter_chip_select_out)
);
`default_nettype wire
